// ==== verilog/dic_pkg.sv ====
// Summary of operation
// - inputs sampled once per millisecond; only step and direction follow every clock
// - input 1 negative limit or step, input 2 positive limit or dir, 3 home
// - pair select 1 joins pins into three differential inputs, 0 six single
// - gate mask bits: 0 negative limit, 1 positive, 2 home, 3 interlock
// - gate mask touches only special bits, never level bits 16 to 31
// - invert mask bit n-1 flips sense of input n, special and level alike
// - step and direction signals bypass the invert mask
// - simulate mask bit n-1 replaces sampled input n with software value
// - software value comes from same bit of simulated levels register
// - unprocessed levels register shows samples after pairing, before any other conditioning
// - input 1 special result in image bit 0, full level in bit 16
// - writing 1 to source map enable selects routing mode
// - routing mode ignores gate bits 0-2, invert, simulate mask and simulated levels
// - enabling routing loads table defaults matching the unrouted behaviour without simulation
// - table entry k drives image bit k
// - image bit 3 is interlock; 0 raises the fault when gate bit 3 is set, 1 permits motion
// - image bits 0-15 special results, bit 15+n level of input n
package dic_pkg;

  // ------------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFF_GATE = 8'h00;
  localparam logic [7:0] OFF_INVERT = 8'h04;
  localparam logic [7:0] OFF_SIM_MASK = 8'h08;
  localparam logic [7:0] OFF_SIM_LEVELS = 8'h0c;
  localparam logic [7:0] OFF_RAW = 8'h10;
  localparam logic [7:0] OFF_PAIR = 8'h14;
  localparam logic [7:0] OFF_MAP_EN = 8'h18;
  localparam logic [7:0] OFF_CTRL = 8'h1c;
  localparam logic [7:0] OFF_DIVIDER = 8'h20;
  localparam logic [7:0] OFF_IMAGE = 8'h24;
  localparam logic [7:0] OFF_STATUS = 8'h28;
  localparam logic [7:0] OFF_MAP_BASE = 8'h80;

  // ------------------------------------------------------------------
  // reset values and timing
  // ------------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0] RST_MAP_ENTRY = 8'h00;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SAMPLE_PERIOD_NS = 1_000_000;
  localparam int TICK_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

  // ------------------------------------------------------------------
  // field positions and sizes
  // ------------------------------------------------------------------
  localparam int NUM_PINS = 6;
  localparam int NUM_AUX = 4;
  localparam int NUM_PHYS = 16;
  localparam int MAP_ENTRIES = 32;
  localparam int IMG_LEVEL_BASE = 16;
  localparam int SF_NEG = 0;
  localparam int SF_POS = 1;
  localparam int SF_HOME = 2;
  localparam int SF_ILOCK = 3;
  localparam int CTRL_CLKDIR = 0;
  localparam int SRC_INV_BIT = 7;

  // ------------------------------------------------------------------
  // routing source codes
  // ------------------------------------------------------------------
  localparam logic [6:0] SRC_PHYS_FIRST = 7'h01;
  localparam logic [6:0] SRC_PHYS_LAST = 7'h10;
  localparam logic [6:0] SRC_ENC_A = 7'h44;
  localparam logic [6:0] SRC_USB = 7'h47;

  // ------------------------------------------------------------------
  // block state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [NUM_PINS+NUM_AUX-1:0] sync1;
    logic [NUM_PINS+NUM_AUX-1:0] sync2;
    logic [31:0] div_cnt;
    logic [31:0] divider;
    logic [31:0] gate;
    logic [31:0] invert;
    logic [31:0] sim_mask;
    logic [31:0] sim_levels;
    logic pair;
    logic route_en;
    logic clkdir;
    logic [NUM_PHYS-1:0] raw;
    logic [31:0] image;
    logic fault;
    logic step;
    logic dir;
    logic tick;
    logic [31:0] rdata;
    logic [MAP_ENTRIES-1:0][7:0] map;
  } state_t;

endpackage : dic_pkg

// ==== verilog/digital_input_conditioning.sv ====
`timescale 1ns/1ps
module digital_input_conditioning
  import dic_pkg::*;
#(
  parameter logic [31:0] TICK_DEFAULT = 32'(TICK_CYCLES)
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [NUM_PINS-1:0] i_pin,
  input wire logic i_enc_a,
  input wire logic i_enc_b,
  input wire logic i_enc_index,
  input wire logic i_usb_power,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic [31:0] o_image,
  output logic o_interlock_fault,
  output logic o_step,
  output logic o_dir,
  output logic o_tick
);

  state_t s_reg;
  state_t s_next;
  logic [NUM_PHYS-1:0] phys;
  logic [NUM_PHYS-1:0] phys_single;
  logic [NUM_PHYS-1:0] phys_diff;
  logic [NUM_AUX-1:0] aux;
  logic [31:0] routed;

  // ------------------------------------------------------------------
  // routing source decode
  // ------------------------------------------------------------------
  function automatic logic route_src(
    input logic [7:0] code,
    input logic [NUM_PHYS-1:0] p,
    input logic [NUM_AUX-1:0] a
  );
    logic [6:0] b;
    logic v;
    b = code[6:0];
    v = 1'b0;
    // codes outside the table read as constant, not as a stale input
    if (b >= SRC_PHYS_FIRST && b <= SRC_PHYS_LAST) begin
      v = p[4'(b - SRC_PHYS_FIRST)];
    end else if (b >= SRC_ENC_A && b <= SRC_USB) begin
      v = a[2'(b - SRC_ENC_A)];
    end
    return v ^ code[SRC_INV_BIT];
  endfunction : route_src

  // ------------------------------------------------------------------
  // pin pairing
  // ------------------------------------------------------------------
  // pins beyond the six fitted read as low
  assign phys_single = {10'h000, s_reg.sync2[NUM_PINS-1:0]};
  // lower pin of a pair is the negative leg
  assign phys_diff = {13'h0000,
                      s_reg.sync2[5] & ~s_reg.sync2[4],
                      s_reg.sync2[3] & ~s_reg.sync2[2],
                      s_reg.sync2[1] & ~s_reg.sync2[0]};
  assign phys = s_reg.pair ? phys_diff : phys_single;
  assign aux = s_reg.sync2[NUM_PINS+NUM_AUX-1:NUM_PINS];

  // ------------------------------------------------------------------
  // routed image, one source per bit
  // ------------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < MAP_ENTRIES; k++) begin : g_route
      assign routed[k] = route_src(s_reg.map[k], phys, aux);
    end
  endgenerate

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    logic [NUM_PINS-1:0] lvl;
    logic [31:0] norm;
    logic [31:0] img_new;
    logic tick;
    s_next = s_reg;
    lvl = '0;
    norm = '0;
    img_new = '0;
    tick = 1'b0;

    // metastability settles in sync1; only sync2 feeds logic
    s_next.sync1 = {i_usb_power, i_enc_index, i_enc_b, i_enc_a, i_pin};
    s_next.sync2 = s_reg.sync1;

    // step and direction follow the pins every clock, never inverted
    s_next.step = phys[0];
    s_next.dir = phys[1];

    // divider of 0 or 1 gives a tick every clock
    if (s_reg.div_cnt + 32'h1 >= s_reg.divider) begin
      tick = 1'b1;
    end
    s_next.div_cnt = tick ? 32'h0 : s_reg.div_cnt + 32'h1;
    s_next.tick = tick;

    // unrouted path: simulate, then invert, then gate
    for (int n = 0; n < NUM_PINS; n++) begin
      lvl[n] = s_reg.sim_mask[n] ? s_reg.sim_levels[n] : phys[n];
      lvl[n] = lvl[n] ^ s_reg.invert[n];
      norm[IMG_LEVEL_BASE + n] = lvl[n];
    end
    // limit roles give way to step and direction in clock-direction use
    norm[SF_NEG] = s_reg.gate[SF_NEG] & lvl[0] & ~s_reg.clkdir;
    norm[SF_POS] = s_reg.gate[SF_POS] & lvl[1] & ~s_reg.clkdir;
    norm[SF_HOME] = s_reg.gate[SF_HOME] & lvl[2];
    // interlock has no pin without routing, so it reads as a stop
    norm[SF_ILOCK] = 1'b0;

    img_new = s_reg.route_en ? routed : norm;
    if (tick) begin
      s_next.raw = phys;
      s_next.image = img_new;
      s_next.fault = s_reg.gate[SF_ILOCK] & ~img_new[SF_ILOCK];
    end

    // register writes
    if (i_wr) begin
      if (i_addr == OFF_GATE) begin
        s_next.gate = i_wdata;
      end else if (i_addr == OFF_INVERT) begin
        s_next.invert = i_wdata;
      end else if (i_addr == OFF_SIM_MASK) begin
        s_next.sim_mask = i_wdata;
      end else if (i_addr == OFF_SIM_LEVELS) begin
        s_next.sim_levels = i_wdata;
      end else if (i_addr == OFF_PAIR) begin
        s_next.pair = i_wdata[0];
      end else if (i_addr == OFF_MAP_EN) begin
        s_next.route_en = i_wdata[0];
        // defaults copy the current masks; forcing cannot be carried over
        if (i_wdata[0] && !s_reg.route_en) begin
          for (int e = 0; e < MAP_ENTRIES; e++) begin
            s_next.map[e] = RST_MAP_ENTRY;
          end
          for (int n = 0; n < NUM_PINS; n++) begin
            s_next.map[IMG_LEVEL_BASE + n] =
              {s_reg.invert[n], 7'(n + 1)};
          end
          for (int n = SF_NEG; n <= SF_HOME; n++) begin
            if (s_reg.gate[n] && !(s_reg.clkdir && n != SF_HOME)) begin
              s_next.map[n] = {s_reg.invert[n], 7'(n + 1)};
            end
          end
        end
      end else if (i_addr == OFF_CTRL) begin
        s_next.clkdir = i_wdata[CTRL_CLKDIR];
      end else if (i_addr == OFF_DIVIDER) begin
        s_next.divider = i_wdata;
      end else if (i_addr >= OFF_MAP_BASE && i_addr[1:0] == 2'b00) begin
        s_next.map[i_addr[6:2]] = i_wdata[7:0];
      end
    end

    // register reads, data valid for exactly one cycle
    s_next.rdata = RST_WORD;
    if (i_rd) begin
      if (i_addr == OFF_GATE) begin
        s_next.rdata = s_reg.gate;
      end else if (i_addr == OFF_INVERT) begin
        s_next.rdata = s_reg.invert;
      end else if (i_addr == OFF_SIM_MASK) begin
        s_next.rdata = s_reg.sim_mask;
      end else if (i_addr == OFF_SIM_LEVELS) begin
        s_next.rdata = s_reg.sim_levels;
      end else if (i_addr == OFF_RAW) begin
        s_next.rdata = {16'h0000, s_reg.raw};
      end else if (i_addr == OFF_PAIR) begin
        s_next.rdata = {31'h0, s_reg.pair};
      end else if (i_addr == OFF_MAP_EN) begin
        s_next.rdata = {31'h0, s_reg.route_en};
      end else if (i_addr == OFF_CTRL) begin
        s_next.rdata = {31'h0, s_reg.clkdir};
      end else if (i_addr == OFF_DIVIDER) begin
        s_next.rdata = s_reg.divider;
      end else if (i_addr == OFF_IMAGE) begin
        s_next.rdata = s_reg.image;
      end else if (i_addr == OFF_STATUS) begin
        s_next.rdata = {31'h0, s_reg.fault};
      end else if (i_addr >= OFF_MAP_BASE && i_addr[1:0] == 2'b00) begin
        s_next.rdata = {24'h000000, s_reg.map[i_addr[6:2]]};
      end
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      s_reg <= '0;
      s_reg.divider <= TICK_DEFAULT;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_rdata = s_reg.rdata;
  assign o_image = s_reg.image;
  assign o_interlock_fault = s_reg.fault;
  assign o_step = s_reg.step;
  assign o_dir = s_reg.dir;
  assign o_tick = s_reg.tick;

endmodule : digital_input_conditioning

// ==== dv/field_sensors.sv ====
`timescale 1ns/1ps
module field_sensors (
  input wire logic i_clk_sys,
  input wire logic [9:0] i_lvl,
  output logic [5:0] o_pin,
  output logic [3:0] o_aux
);
  // switches and encoder lines move only just after a clock edge
  always @(posedge i_clk_sys) begin
    o_pin <= i_lvl[5:0];
    o_aux <= i_lvl[9:6];
  end
endmodule : field_sensors

// ==== dv/digital_input_conditioning_assertions.sv ====
`timescale 1ns/1ps
module dic_checker
  import dic_pkg::*;
#(
  parameter logic [31:0] TICK_DEFAULT = 32'h8
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [NUM_PINS-1:0] i_pin,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] o_rdata,
  input wire logic [31:0] o_image,
  input wire logic o_interlock_fault,
  input wire logic o_step,
  input wire logic o_dir,
  input wire logic o_tick
);
  logic [31:0] gap_reg;
  logic seen_reg;
  logic [2:0] live_reg;
  // live_reg keeps $past depth 3 clear of reset-time pin values
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      gap_reg <= 32'h0;
      seen_reg <= 1'b0;
      live_reg <= 3'h0;
    end else begin
      gap_reg <= o_tick ? 32'h0 : gap_reg + 32'h1;
      seen_reg <= seen_reg | o_tick;
      live_reg <= (live_reg == 3'h7) ? live_reg : live_reg + 3'h1;
    end
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  sequence s_rd_img;
    i_rd && i_addr == OFF_IMAGE;
  endsequence
  sequence s_rd_stat;
    i_rd && i_addr == OFF_STATUS;
  endsequence
  a_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data not idle");
  a_image_read: assert property (s_rd_img |=> o_rdata == $past(o_image))
    else $error("image read wrong");
  a_status_read: assert property (s_rd_stat |=>
    o_rdata == {31'h0, $past(o_interlock_fault)})
    else $error("status read wrong");
  a_image_on_tick: assert property ($changed(o_image) |-> o_tick)
    else $error("image moved off tick");
  a_fault_on_tick: assert property ($changed(o_interlock_fault) |-> o_tick)
    else $error("fault moved off tick");
  a_tick_period: assert property (o_tick && seen_reg |->
    gap_reg == TICK_DEFAULT - 32'h1)
    else $error("tick period wrong");
  a_step_bypass: assert property (live_reg == 3'h7 |->
    o_step == $past(i_pin[0], 3) || o_step == $past(i_pin[1] & ~i_pin[0], 3))
    else $error("step not raw input 1");
  a_dir_bypass: assert property (live_reg == 3'h7 |->
    o_dir == $past(i_pin[1], 3) || o_dir == $past(i_pin[3] & ~i_pin[2], 3))
    else $error("dir not raw input 2");
endmodule : dic_checker

// ==== dv/digital_input_conditioning_tb.sv ====
`timescale 1ns/1ps
module digital_input_conditioning_tb;
  import dic_pkg::*;
  logic i_clk_sys, i_resetn, i_wr, i_rd, rd_d, o_tick;
  logic o_interlock_fault, o_step, o_dir;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, o_image, g, iv, seed;
  logic cd;
  logic [9:0] lvl;
  logic [5:0] i_pin;
  logic [3:0] aux;
  logic [31:0] q[$];
  int error_cnt, n_tests, cyc;
  field_sensors u_field_sensors (.i_clk_sys(i_clk_sys), .i_lvl(lvl),
    .o_pin(i_pin), .o_aux(aux));
  digital_input_conditioning #(.TICK_DEFAULT(32'h8))
    u_digital_input_conditioning (.i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn), .i_pin(i_pin), .i_enc_a(aux[0]),
    .i_enc_b(aux[1]), .i_enc_index(aux[2]), .i_usb_power(aux[3]),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_image(o_image),
    .o_interlock_fault(o_interlock_fault), .o_step(o_step),
    .o_dir(o_dir), .o_tick(o_tick));
  function automatic logic [31:0] ex(logic [5:0] p, logic [5:0] sm,
      logic [5:0] sv);
    logic [5:0] l;
    l = ((sm & sv) | (~sm & p)) ^ iv[5:0];
    return {10'h0, l, 12'h0, 1'b0, g[2] & l[2],
      g[1:0] & l[1:0] & ~{cd, cd}};
  endfunction : ex
  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic close_out;
    if (error_cnt == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    q.push_back(e);
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
  endtask : rd
  // new random levels, then three ticks to pass sync and sampling
  task automatic shake;
    @(posedge i_clk_sys);
    seed = lfsr(seed);
    lvl <= seed[9:0];
    repeat (3) @(posedge o_tick);
  endtask : shake
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    rd_d <= i_rd;
    if (rd_d)
      chk("rdata", q.pop_front(), o_rdata);
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    {i_resetn, i_wr, i_rd, i_addr, i_wdata, lvl, cd} = '0;
    seed = 32'hf431;
    g = 32'h7;
    iv = 32'h2;
    repeat (20) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    rd(OFF_GATE, 32'h0);
    rd(8'h30, 32'h0);
    wr(OFF_GATE, g);
    wr(OFF_INVERT, iv);
    rd(OFF_GATE, g);
    for (int i = 0; i < 3; i++) begin
      shake();
      rd(OFF_RAW, {26'h0, lvl[5:0]});
      rd(OFF_IMAGE, ex(lvl[5:0], 6'h0, 6'h0));
    end
    wr(OFF_SIM_MASK, 32'h1);
    wr(OFF_SIM_LEVELS, 32'h1);
    shake();
    rd(OFF_IMAGE, ex(lvl[5:0], 6'h1, 6'h1));
    wr(OFF_SIM_MASK, 32'h0);
    wr(OFF_PAIR, 32'h1);
    shake();
    rd(OFF_IMAGE, ex({3'h0, lvl[5] & ~lvl[4], lvl[3] & ~lvl[2],
      lvl[1] & ~lvl[0]}, 6'h0, 6'h0));
    wr(OFF_PAIR, 32'h0);
    g = 32'hf;
    wr(OFF_GATE, g);
    shake();
    rd(OFF_IMAGE, ex(lvl[5:0], 6'h0, 6'h0));
    rd(OFF_STATUS, 32'h1);
    // clock-direction use takes both limit roles away
    cd = 1'b1;
    wr(OFF_CTRL, 32'h1);
    shake();
    rd(OFF_CTRL, 32'h1);
    rd(OFF_IMAGE, ex(lvl[5:0], 6'h0, 6'h0));
    wr(OFF_MAP_EN, 32'h1);
    rd(8'hc0, 32'h1);
    rd(8'hc4, 32'h82);
    rd(8'h80, 32'h0);
    rd(8'h88, 32'h3);
    wr(OFF_INVERT, 32'h3f);
    wr(OFF_SIM_MASK, 32'h3f);
    wr(8'h80, 32'h44);
    wr(8'h84, 32'hc7);
    wr(8'h8c, 32'h80);
    wr(8'hc0, 32'h81);
    shake();
    rd(OFF_IMAGE, {10'h0, lvl[5:2], ~lvl[1:0], 12'h0, 1'b1,
      lvl[2], ~lvl[9], lvl[6]});
    rd(OFF_STATUS, 32'h0);
    repeat (2) @(posedge i_clk_sys);
    close_out();
  end
endmodule : digital_input_conditioning_tb
bind digital_input_conditioning dic_checker #(.TICK_DEFAULT(32'h8))
  u_dic_checker (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
  .i_pin(i_pin), .i_rd(i_rd), .i_addr(i_addr), .o_rdata(o_rdata),
  .o_image(o_image), .o_interlock_fault(o_interlock_fault),
  .o_step(o_step), .o_dir(o_dir), .o_tick(o_tick));
